// *** include/csx_pkg.sv ***
`default_nettype none
package csx_pkg;

  // Instruction field encodings.
  localparam logic [4:0] CSX_OP_STORE_HALF = 5'h19;
  localparam logic [4:0] CSX_OP_SHIFT      = 5'h06;
  localparam logic [4:0] CSX_OP_REG_REG    = 5'h1D;
  localparam logic [4:0] CSX_OP_SCMP_IMM   = 5'h0A;
  localparam logic [4:0] CSX_OP_UCMP_IMM   = 5'h0B;
  localparam logic [4:0] CSX_OP_EXTEND     = 5'h1E;
  localparam logic [1:0] CSX_FN_SHL_IMM    = 2'h0;
  localparam logic [4:0] CSX_FN_SHL_VAR    = 5'h04;
  localparam logic [4:0] CSX_FN_SCMP       = 5'h02;
  localparam logic [5:0] CSX_EXT_ZERO6     = 6'h00;
  localparam logic [2:0] CSX_ZERO3         = 3'h0;
  localparam logic [5:0] CSX_SHIFT_ZERO_AS = 6'h08;
  localparam logic [4:0] CSX_COMPARE_DEST  = 5'h18;

  // Operation selected by the decoder.
  typedef enum logic [2:0] {
    CSX_NONE,
    CSX_STORE,
    CSX_SHIFT,
    CSX_CMP
  } csx_kind_type;

  // Request from the decode stage.
  typedef struct packed {
    logic        valid;
    logic        extended;
    logic [15:0] ext_word;
    logic [15:0] insn;
  } csx_req_type;

  // Register write back.
  typedef struct packed {
    logic        valid;
    logic [4:0]  index;
    logic [31:0] data;
  } csx_wb_type;

  // Store issued to the memory system.
  typedef struct packed {
    logic        valid;
    logic [31:0] paddr;
    logic [2:0]  cca;
    logic [15:0] data;
  } csx_store_type;

  // Exception report.
  typedef struct packed {
    logic valid;
    logic addr_err;
    logic tlb_refill;
    logic tlb_invalid;
    logic tlb_modified;
    logic bus_err;
  } csx_exc_type;

endpackage : csx_pkg
`default_nettype wire

// *** design/csx_reg_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module csx_reg_map
  import csx_pkg::*;
(
  input  wire logic [2:0] field,
  output logic      [4:0] index
);

  // Compact register fields reach registers 16, 17 and 2 to 7.
  always_comb begin
    unique case (field)
      3'h0: index = 5'h10;
      3'h1: index = 5'h11;
      3'h2: index = 5'h02;
      3'h3: index = 5'h03;
      3'h4: index = 5'h04;
      3'h5: index = 5'h05;
      3'h6: index = 5'h06;
      3'h7: index = 5'h07;
    endcase
  end

endmodule : csx_reg_map
`default_nettype wire

// *** design/csx_datapath.sv ***
// What this block does
// - Compact store address: offset times two plus base
// - Store writes only the low halfword
// - Odd store address suppresses store, raises error
// - Extended store offset: split sixteen bits, sign-extended
// - Stores report translation, bus and address faults
// - Compact shift field zero means eight
// - Immediate shift zero-fills into first register
// - Extended shift zero fields, amount 0 to 31
// - Variable shift by low five bits, into second
// - Signed register compare writes register 24
// - Compact signed immediate compare, zero-extended immediate
// - Extended signed immediate compare, sign-extended immediate
// - Unsigned immediate compare: compact zero-extends, extended sign-extends immediate
`timescale 1ns/1ps
`default_nettype none
module csx_datapath
  import csx_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire csx_req_type   req,
  output logic      [4:0]    rd_a_index,
  input  wire logic [31:0]   rd_a_data,
  output logic      [4:0]    rd_b_index,
  input  wire logic [31:0]   rd_b_data,
  output logic      [31:0]   xlat_vaddr,
  output logic               xlat_req,
  input  wire logic [31:0]   xlat_paddr,
  input  wire logic [2:0]    xlat_cca,
  input  wire logic          xlat_refill,
  input  wire logic          xlat_invalid,
  input  wire logic          xlat_modified,
  input  wire logic          bus_err,
  output csx_wb_type         wb,
  output csx_store_type      store,
  output csx_exc_type        exc,
  output logic      [31:0]   bad_vaddr
);

  logic [15:0]  insn;
  logic [15:0]  ext;
  logic [4:0]   major;
  logic [4:0]   idx_a;
  logic [4:0]   idx_b;
  csx_kind_type kind;
  logic [31:0]  op_a;
  logic [31:0]  op_b;
  logic [31:0]  imm;
  logic [31:0]  vaddr;
  logic [4:0]   shamt;
  logic [4:0]   wr_index;
  logic [31:0]  result;
  logic         misaligned;
  logic         store_fault;

  assign insn  = req.insn;
  assign ext   = req.ext_word;
  assign major = insn[15:11];

  // Both field positions go through the fixed mapping before the file is read.
  csx_reg_map u_map_a (
    .field (insn[10:8]),
    .index (idx_a)
  );
  csx_reg_map u_map_b (
    .field (insn[7:5]),
    .index (idx_b)
  );

  assign rd_a_index = idx_a;
  assign rd_b_index = idx_b;
  assign op_a       = rd_a_data;
  assign op_b       = rd_b_data;

  // Decode: reserved zero fields of extended forms must hold or nothing runs.
  always_comb begin
    kind     = CSX_NONE;
    imm      = '0;
    shamt    = '0;
    wr_index = idx_a;
    // An extended pair whose prefix is not the extend code is refused outright.
    if (req.valid && (!req.extended || ext[15:11] == CSX_OP_EXTEND)) begin
      unique case (major)
        CSX_OP_STORE_HALF: begin
          kind = CSX_STORE;
          if (req.extended) begin
            imm = {{16{ext[4]}}, ext[4:0], ext[10:5], insn[4:0]};
          end else begin
            imm = {26'h0, insn[4:0], 1'b0};
          end
        end
        CSX_OP_SHIFT: begin
          if (insn[1:0] == CSX_FN_SHL_IMM) begin
            if (!req.extended) begin
              kind  = CSX_SHIFT;
              shamt = (insn[4:2] == CSX_ZERO3) ? CSX_SHIFT_ZERO_AS[4:0]
                                               : {2'h0, insn[4:2]};
            end else if (ext[5:0] == CSX_EXT_ZERO6 && insn[4:2] == CSX_ZERO3) begin
              kind  = CSX_SHIFT;
              shamt = ext[10:6];
            end
          end
        end
        CSX_OP_REG_REG: begin
          if (!req.extended && insn[4:0] == CSX_FN_SHL_VAR) begin
            kind     = CSX_SHIFT;
            shamt    = op_a[4:0];
            wr_index = idx_b;
          end else if (!req.extended && insn[4:0] == CSX_FN_SCMP) begin
            kind = CSX_CMP;
          end
        end
        CSX_OP_SCMP_IMM, CSX_OP_UCMP_IMM: begin
          if (!req.extended) begin
            kind = CSX_CMP;
            imm  = {24'h0, insn[7:0]};
          end else if (insn[7:5] == CSX_ZERO3) begin
            kind = CSX_CMP;
            imm  = {{16{ext[4]}}, ext[4:0], ext[10:5], insn[4:0]};
          end
        end
        default: kind = CSX_NONE;
      endcase
    end
  end

  // Effective address and the compare or shift result.
  always_comb begin
    vaddr  = op_a + imm;
    result = '0;
    if (kind == CSX_SHIFT) begin
      result = op_b << shamt;
    end else if (kind == CSX_CMP) begin
      if (major == CSX_OP_REG_REG) begin
        result = {31'h0, $signed(op_a) < $signed(op_b)};
      end else if (major == CSX_OP_SCMP_IMM) begin
        result = {31'h0, $signed(op_a) < $signed(imm)};
      end else begin
        result = {31'h0, op_a < imm};
      end
    end
  end

  // Translation is asked only for well aligned stores.
  assign misaligned  = (kind == CSX_STORE) && vaddr[0];
  assign xlat_req    = (kind == CSX_STORE) && !vaddr[0];
  assign xlat_vaddr  = vaddr;
  assign store_fault = xlat_refill | xlat_invalid | xlat_modified | bus_err;

  // Register write back, one cycle after the request.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb <= '0;
    end else begin
      wb.valid <= (kind == CSX_SHIFT) || (kind == CSX_CMP);
      wb.index <= (kind == CSX_CMP) ? CSX_COMPARE_DEST : wr_index;
      wb.data  <= result;
    end
  end

  // Store issue; a fault of any kind holds the store back.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      store <= '0;
    end else begin
      store.valid <= xlat_req && !store_fault;
      store.paddr <= xlat_paddr;
      store.cca   <= xlat_cca;
      store.data  <= op_b[15:0];
    end
  end

  // Exception report with the faulting virtual address.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exc       <= '0;
      bad_vaddr <= '0;
    end else begin
      exc.addr_err     <= misaligned;
      exc.tlb_refill   <= xlat_req && xlat_refill;
      exc.tlb_invalid  <= xlat_req && xlat_invalid;
      exc.tlb_modified <= xlat_req && xlat_modified;
      exc.bus_err      <= xlat_req && bus_err;
      exc.valid        <= misaligned || (xlat_req && store_fault);
      bad_vaddr        <= vaddr;
    end
  end

  // The store never issues for an odd address.
  store_align_a: assert property (@(posedge clk) disable iff (!rst_n)
    misaligned |=> !store.valid && exc.addr_err) else $error("odd store issued");

  // Compare results always land in register 24 as zero or one.
  cmp_dest_a: assert property (@(posedge clk) disable iff (!rst_n)
    kind == CSX_CMP |=> wb.valid && wb.index == CSX_COMPARE_DEST && wb.data[31:1] == 31'h0)
    else $error("compare write back wrong");

  // A compact zero shift field shifts by eight.
  shift_eight_a: assert property (@(posedge clk) disable iff (!rst_n)
    (kind == CSX_SHIFT && !req.extended && major == CSX_OP_SHIFT && insn[4:2] == CSX_ZERO3)
    |=> wb.data == ($past(op_b) << CSX_SHIFT_ZERO_AS)) else $error("zero shift not eight");

  // A faulting translation blocks the store.
  fault_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    xlat_req && store_fault |=> !store.valid && exc.valid) else $error("fault store issued");

  // Stored data is the low halfword of the source.
  store_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    xlat_req |=> store.data == $past(op_b[15:0])) else $error("store data wrong");

  // Compact store address is base plus twice the offset.
  store_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (kind == CSX_STORE && !req.extended)
    |=> bad_vaddr == $past(op_a) + {26'h0, $past(insn[4:0]), 1'b0})
    else $error("store address wrong");

  // Variable shift writes back into the second register.
  var_dest_a: assert property (@(posedge clk) disable iff (!rst_n)
    (kind == CSX_SHIFT && major == CSX_OP_REG_REG) |=> wb.index == $past(idx_b))
    else $error("variable shift destination wrong");

  // Unsigned compare follows unsigned order.
  ucmp_order_a: assert property (@(posedge clk) disable iff (!rst_n)
    (kind == CSX_CMP && major == CSX_OP_UCMP_IMM) |=> wb.data[0] == ($past(op_a) < $past(imm)))
    else $error("unsigned compare wrong");

endmodule : csx_datapath
`default_nettype wire

// *** tb/csx_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module csx_far_model
  import csx_pkg::*;
#(
  parameter logic [31:0] XMASK = 32'h4000_0000,
  parameter logic [2:0]  CCA   = 3'h3
)(
  input  wire logic [4:0]  rd_a_index,
  input  wire logic [4:0]  rd_b_index,
  output logic      [31:0] rd_a_data,
  output logic      [31:0] rd_b_data,
  input  wire logic        xlat_req,
  input  wire logic [31:0] xlat_vaddr,
  input  wire logic [3:0]  fault,
  output logic      [31:0] xlat_paddr,
  output logic      [2:0]  xlat_cca,
  output logic             xlat_refill,
  output logic             xlat_invalid,
  output logic             xlat_modified,
  output logic             bus_err
);
  logic [31:0] gpr [32];
  // Register file answers in the cycle it is read.
  assign rd_a_data = gpr[rd_a_index];
  assign rd_b_data = gpr[rd_b_index];
  // Unasked translation shows inverted address and attribute lines and no faults, so stale values never pass.
  assign xlat_paddr = xlat_req ? (xlat_vaddr ^ XMASK) : ~xlat_vaddr;
  assign xlat_cca   = xlat_req ? CCA : ~CCA;
  assign {xlat_refill, xlat_invalid, xlat_modified, bus_err} = xlat_req ? fault : 4'h0;
endmodule : csx_far_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
  import csx_pkg::*;
;
  localparam logic [31:0] XMASK = 32'h4000_0000;
  localparam logic [2:0]  CCA   = 3'h3;
  localparam logic [31:0] V5    = 32'hABCD_1234;
  logic          clk   = 1'b0;
  logic          rst_n = 1'b0;
  csx_req_type   req   = '0;
  logic [3:0]    fault = 4'h0;
  logic [4:0]    rd_a_index, rd_b_index;
  logic [31:0]   rd_a_data, rd_b_data, xlat_vaddr, xlat_paddr, bad_vaddr;
  logic          xlat_req, xlat_refill, xlat_invalid, xlat_modified, bus_err;
  logic [2:0]    xlat_cca;
  csx_wb_type    wb;
  csx_store_type store;
  csx_exc_type   exc;
  int            errors = 0;
  int            total_checks = 0;

  // The clock toggles every 4 ns, half of its 8 ns period.
  always #4 clk = ~clk;

  csx_datapath u_dut (.clk(clk), .rst_n(rst_n), .req(req), .rd_a_index(rd_a_index),
    .rd_a_data(rd_a_data), .rd_b_index(rd_b_index), .rd_b_data(rd_b_data),
    .xlat_vaddr(xlat_vaddr), .xlat_req(xlat_req), .xlat_paddr(xlat_paddr),
    .xlat_cca(xlat_cca), .xlat_refill(xlat_refill), .xlat_invalid(xlat_invalid),
    .xlat_modified(xlat_modified), .bus_err(bus_err), .wb(wb), .store(store),
    .exc(exc), .bad_vaddr(bad_vaddr));

  csx_far_model #(.XMASK(XMASK), .CCA(CCA)) u_far (.rd_a_index(rd_a_index),
    .rd_b_index(rd_b_index), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data),
    .xlat_req(xlat_req), .xlat_vaddr(xlat_vaddr), .fault(fault),
    .xlat_paddr(xlat_paddr), .xlat_cca(xlat_cca), .xlat_refill(xlat_refill),
    .xlat_invalid(xlat_invalid), .xlat_modified(xlat_modified), .bus_err(bus_err));

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // One request in one cycle; the answer pulse is looked at just after its edge.
  task automatic op(input logic e, input logic [15:0] ew, input logic [15:0] insn);
    @(posedge clk);
    req <= '{1'b1, e, ew, insn};
    @(posedge clk);
    req <= '0;
    #1;
  endtask : op

  function automatic logic [15:0] xp(input logic [15:0] v);
    return {5'h1E, v[10:5], v[15:11]};
  endfunction : xp

  task automatic rw(input logic e, input logic [15:0] ew, input logic [15:0] insn,
                    input logic [4:0] i, input logic [31:0] d);
    op(e, ew, insn);
    chk({26'h0, wb}, {26'h0, 1'b1, i, d});
  endtask : rw

  task automatic t_shift;
    rw(1'b0, 16'h0, {5'h06, 3'h1, 3'h5, 3'h0, 2'h0}, 5'h11, V5 << 8);
    rw(1'b0, 16'h0, {5'h06, 3'h1, 3'h5, 3'h3, 2'h0}, 5'h11, V5 << 3);
    rw(1'b1, 16'hF000, {5'h06, 3'h1, 3'h5, 3'h0, 2'h0}, 5'h11, V5);
    rw(1'b1, 16'hF7C0, {5'h06, 3'h0, 3'h5, 3'h0, 2'h0}, 5'h10, V5 << 31);
    op(1'b1, 16'hF041, {5'h06, 3'h0, 3'h5, 3'h0, 2'h0});
    chk({63'h0, wb.valid}, 64'h0);
    rw(1'b0, 16'h0, {5'h1D, 3'h6, 3'h5, 5'h04}, 5'h05, V5 << 3);
    $display("shift test done");
  endtask : t_shift

  task automatic t_cmp;
    rw(1'b0, 16'h0, {5'h1D, 3'h0, 3'h1, 5'h02}, 5'h18, 32'h1);
    rw(1'b0, 16'h0, {5'h1D, 3'h1, 3'h0, 5'h02}, 5'h18, 32'h0);
    rw(1'b0, 16'h0, {5'h0A, 3'h1, 8'hFF}, 5'h18, 32'h1);
    rw(1'b0, 16'h0, {5'h0A, 3'h0, 8'h00}, 5'h18, 32'h1);
    rw(1'b1, xp(16'hFFFF), {5'h0A, 3'h1, 3'h0, 5'h1F}, 5'h18, 32'h0);
    rw(1'b1, xp(16'hFFFF), {5'h0A, 3'h0, 3'h0, 5'h1F}, 5'h18, 32'h1);
    rw(1'b0, 16'h0, {5'h0B, 3'h0, 8'h05}, 5'h18, 32'h0);
    rw(1'b0, 16'h0, {5'h0B, 3'h1, 8'h06}, 5'h18, 32'h1);
    rw(1'b1, xp(16'hFFFF), {5'h0B, 3'h1, 3'h0, 5'h1F}, 5'h18, 32'h1);
    // A nonzero reserved field or a missing extend prefix must write nothing.
    op(1'b1, xp(16'hFFFF), {5'h0A, 3'h1, 3'h1, 5'h1F});
    chk({63'h0, wb.valid}, 64'h0);
    op(1'b1, 16'h07FF, {5'h0A, 3'h1, 3'h0, 5'h1F});
    chk({63'h0, wb.valid}, 64'h0);
    $display("compare test done");
  endtask : t_cmp

  task automatic t_store;
    op(1'b0, 16'h0, {5'h19, 3'h3, 3'h5, 5'h1F});
    chk({12'h0, store}, {12'h0, 1'b1, 32'h103E ^ XMASK, CCA, V5[15:0]});
    op(1'b1, xp(16'hFFFE), {5'h19, 3'h3, 3'h5, 5'h1E});
    chk({12'h0, store}, {12'h0, 1'b1, 32'h0FFE ^ XMASK, CCA, V5[15:0]});
    op(1'b0, 16'h0, {5'h19, 3'h4, 3'h5, 5'h00});
    chk({25'h0, store.valid, exc, bad_vaddr}, {32'h30, 32'h1001});
    op(1'b1, xp(16'h0001), {5'h19, 3'h3, 3'h5, 5'h01});
    chk({58'h0, exc}, 64'h30);
    // Each translation or bus fault must cancel the store and be reported alone.
    // The fault lines change only on a rising edge, once per iteration.
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      fault <= 4'h8 >> i;
      op(1'b0, 16'h0, {5'h19, 3'h3, 3'h5, 5'h02});
      chk({57'h0, store.valid, exc}, {58'h0, 2'h2, 4'h8 >> i});
    end
    @(posedge clk);
    fault <= 4'h0;
    $display("store test done");
  endtask : t_store

  // A hang is cut short well beyond the sixty or so cycles the tests need.
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    finish_test();
  end

  // Main sequence: load registers, reset, run the tests.
  initial begin
    for (int i = 0; i < 32; i++) u_far.gpr[i] = 32'h0;
    u_far.gpr[16] = 32'h8000_0001;
    u_far.gpr[17] = 32'h0000_0005;
    u_far.gpr[3]  = 32'h0000_1000;
    u_far.gpr[4]  = 32'h0000_1001;
    u_far.gpr[5]  = V5;
    u_far.gpr[6]  = 32'hFFFF_FFE3;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({29'h0, wb.valid, store.valid, exc.valid, bad_vaddr}, 64'h0);
    t_shift();
    t_cmp();
    t_store();
    finish_test();
  end
endmodule : tb
`default_nettype wire
